// >>> hw/idtc_consts.svh
// Constants for the input regulation and safety timer configuration register
`ifndef IDTC_CONSTS_SVH
`define IDTC_CONSTS_SVH
`define IDTC_ADDR 8'h0B
`define IDTC_RESET_VAL 8'h42
`define IDTC_BIT_REG_DIS 7
`define IDTC_BIT_CODE_HI 6
`define IDTC_BIT_CODE_LO 4
`define IDTC_BIT_HALF 3
`define IDTC_BIT_TMR_HI 2
`define IDTC_BIT_TMR_LO 1
`define IDTC_WR_MASK 8'hFE
`define IDTC_GRST_ADDR 8'h09
`define IDTC_GRST_BIT 7
`define IDTC_THR_BASE_MV 16'd4200
`define IDTC_THR_STEP_MV 16'd100
`define IDTC_LIMIT_30M_MIN 10'd30
`define IDTC_LIMIT_3H_MIN 10'd180
`define IDTC_LIMIT_9H_MIN 10'd540
`endif

// >>> hw/idtc_pkg.sv
// Types for the input regulation and safety timer configuration register
package idtc_pkg;
    typedef enum logic [1:0] {
        IDTC_TMR_30M = 2'b00,
        IDTC_TMR_3H = 2'b01,
        IDTC_TMR_9H = 2'b10,
        IDTC_TMR_OFF = 2'b11
    } idtc_limit_t;
    typedef enum logic [1:0] {
        IDTC_PH_IDLE = 2'b00,
        IDTC_PH_CC = 2'b01,
        IDTC_PH_CV = 2'b11,
        IDTC_PH_OTHER = 2'b10
    } idtc_phase_t;
endpackage

// >>> hw/idtc_limit_decode.sv
// Safety time limit decoder: code to minutes and timer enable
`timescale 1ns/10ps
`include "idtc_consts.svh"
module idtc_limit_decode (
    // Code
    input wire logic [1:0] code,
    // Decoded
    output logic [9:0] minutes,
    output logic timer_on
);
    always_comb begin
        minutes = 10'd0;
        timer_on = 1'b1;
        case (idtc_pkg::idtc_limit_t'(code))
            idtc_pkg::IDTC_TMR_30M: minutes = `IDTC_LIMIT_30M_MIN;
            idtc_pkg::IDTC_TMR_3H: minutes = `IDTC_LIMIT_3H_MIN;
            idtc_pkg::IDTC_TMR_9H: minutes = `IDTC_LIMIT_9H_MIN;
            default: timer_on = 1'b0;
        endcase
    end
endmodule // idtc_limit_decode

// >>> hw/idtc_cfg_reg.sv
// Input regulation and safety timer configuration register
`timescale 1ns/10ps
`include "idtc_consts.svh"
module idtc_cfg_reg (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port from the serial interface
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // Charger phase
    input wire logic [1:0] charge_phase,
    // Configuration outputs
    output logic input_regulation_disable,
    output logic [2:0] input_threshold_code,
    output logic [15:0] input_threshold_mv,
    output logic timer_half_rate_enable,
    output logic [1:0] safety_time_limit,
    output logic [9:0] limit_minutes,
    output logic timer_enable,
    output logic timer_half_rate,
    output logic global_reset_pulse
);
    localparam logic [7:0] RST_VAL = `IDTC_RESET_VAL;
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    logic grst;
    logic wr_hit;
    logic [9:0] min_dec;
    logic on_dec;
    logic [15:0] thr_nxt;
    logic half_nxt;

    assign wr_hit = reg_wr && (reg_addr == `IDTC_ADDR);
    // Global reset request seen at address 8'h09, bit 7, not at this register
    assign grst = reg_wr && (reg_addr == `IDTC_GRST_ADDR) && reg_wdata[`IDTC_GRST_BIT];

    always_comb begin
        cfg_nxt = cfg_r;
        if (grst) begin
            cfg_nxt = `IDTC_RESET_VAL;
        end else if (wr_hit) begin
            cfg_nxt = reg_wdata & `IDTC_WR_MASK;
        end
    end

    // Defaults stay until a host write lands
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_r <= `IDTC_RESET_VAL;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
            reg_hit <= 1'b0;
        end else begin
            reg_hit <= (reg_rd || reg_wr) && (reg_addr == `IDTC_ADDR);
            if (reg_rd && reg_addr == `IDTC_ADDR) begin
                reg_rdata <= cfg_r & `IDTC_WR_MASK;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    idtc_limit_decode u_dec (
        .code(cfg_nxt[`IDTC_BIT_TMR_HI:`IDTC_BIT_TMR_LO]),
        .minutes(min_dec),
        .timer_on(on_dec)
    );

    // Threshold in millivolts, computed from the next value so outputs track the register
    assign thr_nxt = `IDTC_THR_BASE_MV
        + 16'(cfg_nxt[`IDTC_BIT_CODE_HI:`IDTC_BIT_CODE_LO]) * `IDTC_THR_STEP_MV;
    // Phase is sampled live, so halving follows the charger one register stage later
    assign half_nxt = cfg_nxt[`IDTC_BIT_HALF]
        && (charge_phase != idtc_pkg::IDTC_PH_CC)
        && (charge_phase != idtc_pkg::IDTC_PH_CV);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            input_regulation_disable <= RST_VAL[`IDTC_BIT_REG_DIS];
            input_threshold_code <= RST_VAL[`IDTC_BIT_CODE_HI:`IDTC_BIT_CODE_LO];
            input_threshold_mv <= `IDTC_THR_BASE_MV
                + 16'(RST_VAL[`IDTC_BIT_CODE_HI:`IDTC_BIT_CODE_LO]) * `IDTC_THR_STEP_MV;
            timer_half_rate_enable <= RST_VAL[`IDTC_BIT_HALF];
            safety_time_limit <= RST_VAL[`IDTC_BIT_TMR_HI:`IDTC_BIT_TMR_LO];
            limit_minutes <= `IDTC_LIMIT_3H_MIN;
            timer_enable <= 1'b1;
            timer_half_rate <= 1'b0;
            global_reset_pulse <= 1'b0;
        end else begin
            input_regulation_disable <= cfg_nxt[`IDTC_BIT_REG_DIS];
            input_threshold_code <= cfg_nxt[`IDTC_BIT_CODE_HI:`IDTC_BIT_CODE_LO];
            input_threshold_mv <= thr_nxt;
            timer_half_rate_enable <= cfg_nxt[`IDTC_BIT_HALF];
            safety_time_limit <= cfg_nxt[`IDTC_BIT_TMR_HI:`IDTC_BIT_TMR_LO];
            limit_minutes <= min_dec;
            timer_enable <= on_dec;
            timer_half_rate <= half_nxt && on_dec;
            global_reset_pulse <= grst;
        end
    end
endmodule // idtc_cfg_reg

// >>> bench/idtc_host_model.sv
// Host model that issues register strobes
`timescale 1ns/10ps
module idtc_host_model (
    // Register port
    output logic [7:0] reg_addr, reg_wdata,
    output logic reg_wr, reg_rd
);
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    // Called off the rising edge so each strobe is steady for one whole cycle
    task drive(input logic w, r, input logic [7:0] a, d);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, r, a, d};
    endtask
endmodule // idtc_host_model

// >>> bench/idtc_cfg_reg_properties.sv
// Assertions on the configuration register ports
`timescale 1ns/10ps
module idtc_cfg_reg_properties (
    // Watched ports
    input logic clk, sys_rst, reg_wr, reg_rd, reg_hit, global_reset_pulse, timer_enable,
    input logic input_regulation_disable, timer_half_rate_enable, timer_half_rate,
    input logic [1:0] charge_phase, safety_time_limit,
    input logic [2:0] input_threshold_code,
    input logic [7:0] reg_addr, reg_wdata, reg_rdata,
    input logic [9:0] limit_minutes,
    input logic [15:0] input_threshold_mv
);
    wire [7:0] c = {input_regulation_disable, input_threshold_code, timer_half_rate_enable,
        safety_time_limit, 1'b0};
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_wr(a); reg_wr && reg_addr == a; endsequence
    chk_wr_cfg: assert property (s_wr(8'h0B) |=> c == ($past(reg_wdata) & 8'hFE))
        else $error("write");
    chk_thr_mv: assert property (input_threshold_mv ==
        16'h1068 + input_threshold_code * 16'h0064) else $error("mv");
    chk_half_rate: assert property ($stable(c) |-> timer_half_rate ==
        (c[3] && timer_enable && !$past(charge_phase[0]))) else $error("half");
    chk_limit_map: assert property ({timer_enable, limit_minutes} == (c[2:1] == 2'b00 ?
        11'h41e : c[2:1] == 2'b01 ? 11'h4b4 : c[2:1] == 2'b10 ? 11'h61c : 11'h000))
        else $error("lim");
    chk_read_back: assert property (reg_rd && reg_addr == 8'h0B |=>
        reg_hit && reg_rdata == c) else $error("read");
    chk_other_adr: assert property ((reg_wr || reg_rd) && reg_addr != 8'h0B |=>
        !reg_hit && !reg_rdata) else $error("other");
    chk_grst_pulse: assert property (s_wr(8'h09) ##0 reg_wdata[7] |=>
        global_reset_pulse && c == 8'h42) else $error("grst");
    chk_hold_cfg: assert property (!reg_wr |=> $stable(c)) else $error("hold");
endmodule // idtc_cfg_reg_properties
bind idtc_cfg_reg idtc_cfg_reg_properties u_props (.*);

// >>> bench/input_dpm_safety_timer_cfg_tb.sv
// Bench comparing the configuration register with a reference model
`timescale 1ns/10ps
module input_dpm_safety_timer_cfg_tb;
    logic clk = 0, sys_rst = 1, reg_wr, reg_rd, reg_hit, global_reset_pulse, k, g, w;
    logic input_regulation_disable, timer_half_rate_enable, timer_enable, timer_half_rate;
    logic [1:0] charge_phase = 0, safety_time_limit;
    logic [2:0] input_threshold_code;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, m, r;
    logic [9:0] limit_minutes;
    logic [15:0] input_threshold_mv;
    // Expected timer enable, half rate, minutes and threshold
    logic e, h;
    logic [9:0] mn;
    logic [15:0] mv;
    int n_mismatch = 0, total_checks = 0, cyc = 0;
    idtc_cfg_reg dut (.*);
    idtc_host_model host (.*);
    initial forever #25 clk = ~clk;
    always @(posedge clk) if (++cyc > 2000) begin
        n_mismatch++;
        close_out();
    end
    task close_out;
        $display("%0d checks, %0d mismatches", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Checks the answer to the previous strobe, then issues the next one
    task op(input logic wr, rd, input logic [7:0] a, d);
        @(negedge clk);
        total_checks++;
        if ({input_regulation_disable, input_threshold_code, timer_half_rate_enable, safety_time_limit,
            reg_rdata, reg_hit, global_reset_pulse} !== {m[7:1], r, k, g}) begin
            $display("[FAIL] %0t register mismatch", $time);
            n_mismatch++;
        end
        total_checks++;
        if ({input_threshold_mv, limit_minutes, timer_enable, timer_half_rate}
            !== {mv, mn, e, h}) begin
            $display("[FAIL] %0t decoded output mismatch", $time);
            n_mismatch++;
        end
        charge_phase = 2'($urandom);
        r = rd && a == 8'h0B ? m : 8'h00;
        k = (wr || rd) && a == 8'h0B;
        g = wr && a == 8'h09 && d[7];
        if (wr && a == 8'h0B) m = d & 8'hFE;
        if (g) m = 8'h42;
        mv = 16'd4200 + 16'(m[6:4]) * 16'd100;
        e = m[2:1] != 2'b11;
        mn = m[2:1] == 2'b00 ? 10'd30 : m[2:1] == 2'b01 ? 10'd180 : m[2:1] == 2'b10 ? 10'd540 : 10'd0;
        h = m[3] && e && charge_phase != 2'b01 && charge_phase != 2'b11;
        host.drive(wr, rd, a, d);
    endtask
    task rst;
        @(negedge clk);
        sys_rst = 1;
        {m, r, k, g} = {8'h42, 10'h000};
        {mv, mn, e, h} = {16'd4600, 10'd180, 1'b1, 1'b0};
        host.drive(0, 0, 8'h00, 8'h00);
        repeat (4) @(negedge clk);
        sys_rst = 0;
    endtask
    initial begin
        void'($urandom(32'h7853));
        rst();
        op(0, 1, 8'h0B, 8'h00);
        $display("reset test done");
        for (int i = 0; i < 800; i++) begin
            w = 1'($urandom);
            op(w, !w, 8'h08 + 8'($urandom % 4), 8'($urandom));
        end
        $display("traffic test done");
        rst();
        op(0, 1, 8'h0B, 8'h00);
        op(0, 0, 8'h00, 8'h00);
        $display("second reset test done");
        close_out();
    end
endmodule // input_dpm_safety_timer_cfg_tb
